// ---- hdl/tra_pkg.sv ----
// Package with constants and types for the transmit/receive DMA arbiter
// Function
// - Transmit requests the bus to fetch or close a descriptor or for a setup packet.
// - Transmit also requests once its FIFO has room for one full data burst.
// - Receive requests the bus to fetch or close a descriptor.
// - Receive requests on a full burst in its FIFO, or at frame end with a short remainder.
// - Receive-space-low is set while free receive FIFO bytes are below the threshold.
// - Transmit-level-low is set while transmit FIFO data is below the threshold.
// - The threshold code selects one of 72, 96, 128 or 160 bytes.
// - No request gives no grant, and a lone requester is always granted.
// - Both requesting while not transmitting grants receive.
// - While transmitting, space-low clear grants transmit; space-low set, level-low clear grants receive.
// - Both lows set grants receive, or alternates round-robin in full duplex.
// - Transmit gets one burst window between two consecutive received packets.
// - Receive gets one burst window between two consecutive transmitted packets.
// - Bus mode register bit 1 sets receive/transmit priority, reset favouring receive.
package tra_pkg;
    // FIFO byte level width in bits
    localparam int LVL_W = 9;
    // Threshold byte levels by code
    localparam logic [LVL_W-1:0] THR_72 = 9'h048;
    localparam logic [LVL_W-1:0] THR_96 = 9'h060;
    localparam logic [LVL_W-1:0] THR_128 = 9'h080;
    localparam logic [LVL_W-1:0] THR_160 = 9'h0a0;
    // Bus mode register bit that sets priority
    localparam int PRIO_BIT = 1;
    // Reset value of priority bit: receive favoured
    localparam logic PRIO_RST = 1'h0;

    typedef enum logic [1:0] {
        TRA_IDLE = 2'b00,
        TRA_TX = 2'b01,
        TRA_RX = 2'b10
    } tra_state_t;

    typedef struct packed {
        tra_state_t st;
        logic rr_rx_last;
        logic rx_win_owed;
        logic tx_win_owed;
    } tra_regs_t;
endpackage

// ---- hdl/tra_thresh.sv ----
`timescale 1ns/100ps
// Threshold decode and both FIFO level comparisons
module tra_thresh
    import tra_pkg::*;
(
    // Threshold code and levels
    input wire logic [1:0] thr_code_i,
    input wire logic [LVL_W-1:0] rx_free_i,
    input wire logic [LVL_W-1:0] tx_level_i,
    // Comparison results
    output logic rx_space_low_o,
    output logic tx_level_low_o
);
    logic [LVL_W-1:0] thr;

    // Code to byte level
    always_comb begin
        unique case (thr_code_i)
            2'h0: thr = THR_72;
            2'h1: thr = THR_96;
            2'h2: thr = THR_128;
            2'h3: thr = THR_160;
        endcase
    end

    // Both compare against the same threshold
    assign rx_space_low_o = rx_free_i < thr;
    assign tx_level_low_o = tx_level_i < thr;
endmodule

// ---- hdl/tra_arbiter.sv ----
`timescale 1ns/100ps
// Transmit/receive DMA bus arbiter with burst hold and packet windows
module tra_arbiter
    import tra_pkg::*;
(
    // Clock and synchronous reset (hardware or software)
    input wire logic clk_i,
    input wire logic rst_i,
    // Configuration from the bus mode and operating registers
    input wire logic [1:0] bus_mode_register_i,
    input wire logic [1:0] thr_code_i,
    input wire logic full_duplex_i,
    // Transmit side conditions
    input wire logic tx_desc_fetch_i,
    input wire logic tx_desc_close_i,
    input wire logic tx_setup_i,
    input wire logic tx_room_burst_i,
    input wire logic [LVL_W-1:0] tx_level_i,
    input wire logic tx_active_i,
    input wire logic tx_pkt_end_i,
    // Receive side conditions
    input wire logic rx_desc_fetch_i,
    input wire logic rx_desc_close_i,
    input wire logic rx_burst_ready_i,
    input wire logic rx_frame_end_i,
    input wire logic rx_data_left_i,
    input wire logic [LVL_W-1:0] rx_free_i,
    input wire logic rx_pkt_end_i,
    // Burst completion from the bus engine
    input wire logic burst_done_i,
    // Requests, grants and indications
    output logic tx_req_o,
    output logic rx_req_o,
    output logic tx_gnt_o,
    output logic rx_gnt_o,
    output logic rx_space_low_o,
    output logic tx_level_low_o
);
    tra_regs_t r_ff;
    tra_regs_t nxt_r;
    logic tx_req;
    logic rx_req;
    logic pick_rx;
    logic tx_prio;

    // Level comparisons live in a small leaf
    tra_thresh tra_thresh_i (
        .thr_code_i(thr_code_i),
        .rx_free_i(rx_free_i),
        .tx_level_i(tx_level_i),
        .rx_space_low_o(rx_space_low_o),
        .tx_level_low_o(tx_level_low_o)
    );

    // Request formation for each side
    assign tx_req = tx_desc_fetch_i | tx_desc_close_i | tx_setup_i
        | tx_room_burst_i;
    assign rx_req = rx_desc_fetch_i | rx_desc_close_i
        | rx_burst_ready_i | (rx_frame_end_i & rx_data_left_i);
    assign tx_req_o = tx_req;
    assign rx_req_o = rx_req;
    // Set bit swaps the default preference to transmit
    assign tx_prio = bus_mode_register_i[PRIO_BIT];

    // Contested decision; windows override the table
    always_comb begin
        if (r_ff.tx_win_owed) begin
            pick_rx = 1'b0;
        end else if (r_ff.rx_win_owed) begin
            pick_rx = 1'b1;
        end else if (!tx_active_i) begin
            pick_rx = !tx_prio;
        end else if (!rx_space_low_o) begin
            pick_rx = 1'b0;
        end else if (!tx_level_low_o) begin
            pick_rx = 1'b1;
        end else if (full_duplex_i) begin
            pick_rx = !r_ff.rr_rx_last;
        end else begin
            pick_rx = !tx_prio;
        end
    end

    // Next state: decide only when idle, hold until burst done
    always_comb begin
        nxt_r = r_ff;
        // Packet end arms the other side's window; a burst clears it
        if (rx_pkt_end_i) begin
            nxt_r.tx_win_owed = 1'b1;
        end
        if (tx_pkt_end_i) begin
            nxt_r.rx_win_owed = 1'b1;
        end
        unique case (r_ff.st)
            TRA_IDLE: begin
                if (tx_req && rx_req) begin
                    nxt_r.st = pick_rx ? TRA_RX : TRA_TX;
                    nxt_r.rr_rx_last = pick_rx;
                end else if (rx_req) begin
                    nxt_r.st = TRA_RX;
                    nxt_r.rr_rx_last = 1'b1;
                end else if (tx_req) begin
                    nxt_r.st = TRA_TX;
                    nxt_r.rr_rx_last = 1'b0;
                end
            end
            TRA_TX: begin
                if (burst_done_i) begin
                    nxt_r.st = TRA_IDLE;
                    // Only the window itself is used up, not later ends
                    if (!rx_pkt_end_i) begin
                        nxt_r.tx_win_owed = 1'b0;
                    end
                end
            end
            TRA_RX: begin
                if (burst_done_i) begin
                    nxt_r.st = TRA_IDLE;
                    if (!tx_pkt_end_i) begin
                        nxt_r.rx_win_owed = 1'b0;
                    end
                end
            end
            default: nxt_r.st = TRA_IDLE;
        endcase
    end

    // State register; reset forgets all history
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r_ff <= '{st: TRA_IDLE, rr_rx_last: 1'b0,
                rx_win_owed: 1'b0, tx_win_owed: 1'b0};
        end else begin
            r_ff <= nxt_r;
        end
    end

    // Grants decode straight from state
    assign tx_gnt_o = (r_ff.st == TRA_TX);
    assign rx_gnt_o = (r_ff.st == TRA_RX);

    // Reset leaves no grant
    a_reset_idle: assert property (@(posedge clk_i)
        rst_i |=> !tx_gnt_o && !rx_gnt_o)
        else $error("grant present after reset");
    // Grant held until burst done
    a_grant_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        tx_gnt_o && !burst_done_i |=> tx_gnt_o)
        else $error("transmit grant dropped mid burst");
    a_grant_rx_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        rx_gnt_o && !burst_done_i |=> rx_gnt_o)
        else $error("receive grant dropped mid burst");
    // Nothing requested from idle means no grant
    a_no_req_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        !tx_gnt_o && !rx_gnt_o && !tx_req && !rx_req
        |=> !tx_gnt_o && !rx_gnt_o)
        else $error("grant without request");
    // A lone request from either side gets that side
    a_lone_rx: assert property (@(posedge clk_i) disable iff (rst_i)
        !tx_gnt_o && !rx_gnt_o && rx_req && !tx_req |=> rx_gnt_o)
        else $error("lone receive request not granted");
    a_lone_tx: assert property (@(posedge clk_i) disable iff (rst_i)
        !tx_gnt_o && !rx_gnt_o && tx_req && !rx_req |=> tx_gnt_o)
        else $error("lone transmit request not granted");
    // Idle contest without transmission, windows or priority bit goes to receive
    a_idle_rx_pref: assert property (@(posedge clk_i) disable iff (rst_i)
        !tx_gnt_o && !rx_gnt_o && tx_req && rx_req && !tx_active_i
        && !tx_prio && !r_ff.tx_win_owed && !r_ff.rx_win_owed |=> rx_gnt_o)
        else $error("receive not preferred when idle");
    // Transmitting with space fine favours transmit
    a_tx_space_ok: assert property (@(posedge clk_i) disable iff (rst_i)
        !tx_gnt_o && !rx_gnt_o && tx_req && rx_req && tx_active_i
        && !rx_space_low_o && !r_ff.tx_win_owed && !r_ff.rx_win_owed
        |=> tx_gnt_o)
        else $error("transmit not chosen with receive space fine");
    // Full duplex round robin gives a contest to the side not granted last
    a_rr_alt: assert property (@(posedge clk_i) disable iff (rst_i)
        !tx_gnt_o && !rx_gnt_o && tx_req && rx_req && tx_active_i
        && rx_space_low_o && tx_level_low_o && full_duplex_i
        && !r_ff.tx_win_owed && !r_ff.rx_win_owed
        |=> rx_gnt_o == !$past(r_ff.rr_rx_last))
        else $error("round robin did not alternate");
    // Owed transmit window wins a contest
    a_tx_window: assert property (@(posedge clk_i) disable iff (rst_i)
        !tx_gnt_o && !rx_gnt_o && tx_req && rx_req && r_ff.tx_win_owed
        |=> tx_gnt_o)
        else $error("transmit window not honoured");
    // Receive request follows frame end with data left
    a_req_map: assert property (@(posedge clk_i) disable iff (rst_i)
        rx_frame_end_i && rx_data_left_i |-> rx_req_o)
        else $error("receive request missing at frame end");
    // Space low with level fine hands the contest to receive
    a_rx_space_pref: assert property (@(posedge clk_i) disable iff (rst_i)
        !tx_gnt_o && !rx_gnt_o && tx_req && rx_req && tx_active_i
        && rx_space_low_o && !tx_level_low_o
        && !r_ff.tx_win_owed && !r_ff.rx_win_owed |=> rx_gnt_o)
        else $error("receive not chosen with receive space low");
    // Both low in half duplex with receive preferred goes to receive
    a_both_low_pref: assert property (@(posedge clk_i) disable iff (rst_i)
        !tx_gnt_o && !rx_gnt_o && tx_req && rx_req && tx_active_i
        && rx_space_low_o && tx_level_low_o && !full_duplex_i && !tx_prio
        && !r_ff.tx_win_owed && !r_ff.rx_win_owed |=> rx_gnt_o)
        else $error("receive not chosen with both levels low");
    // Owed receive window wins a contest when no transmit window waits
    a_rx_window: assert property (@(posedge clk_i) disable iff (rst_i)
        !tx_gnt_o && !rx_gnt_o && tx_req && rx_req
        && !r_ff.tx_win_owed && r_ff.rx_win_owed |=> rx_gnt_o)
        else $error("receive window not honoured");
    // Priority bit set swaps the idle contest to transmit
    a_tx_prio_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        !tx_gnt_o && !rx_gnt_o && tx_req && rx_req && !tx_active_i
        && tx_prio && !r_ff.tx_win_owed && !r_ff.rx_win_owed |=> tx_gnt_o)
        else $error("transmit not preferred with priority bit set");
    // Packet ends always arm the window, even against a clearing burst
    a_tx_win_arm: assert property (@(posedge clk_i) disable iff (rst_i)
        rx_pkt_end_i |=> r_ff.tx_win_owed)
        else $error("transmit window not armed");
    a_rx_win_arm: assert property (@(posedge clk_i) disable iff (rst_i)
        tx_pkt_end_i |=> r_ff.rx_win_owed)
        else $error("receive window not armed");
    // A finished transmit burst uses the window up
    a_tx_win_used: assert property (@(posedge clk_i) disable iff (rst_i)
        tx_gnt_o && burst_done_i && !rx_pkt_end_i |=> !r_ff.tx_win_owed)
        else $error("transmit window kept after its burst");
    // Decisions only between bursts: one idle cycle after each burst
    a_idle_gap: assert property (@(posedge clk_i) disable iff (rst_i)
        (tx_gnt_o || rx_gnt_o) && burst_done_i |=> !tx_gnt_o && !rx_gnt_o)
        else $error("no idle cycle after burst");
    // Never both sides on the bus at once
    a_grant_excl: assert property (@(posedge clk_i) disable iff (rst_i)
        !(tx_gnt_o && rx_gnt_o))
        else $error("both sides granted");
endmodule

// ---- bench/tra_dma_model.sv ----
// Bus engine model that finishes each granted burst
`timescale 1ns/100ps
module tra_dma_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Grants and burst length in beats minus one
    input wire logic tx_gnt_i,
    input wire logic rx_gnt_i,
    input wire logic [1:0] len_i,
    // One-cycle pulse on the last beat
    output logic burst_done_o
);
    logic [1:0] beat_ff;

    // Done only while granted, so it never shows up while idle
    assign burst_done_o = (tx_gnt_i | rx_gnt_i) && beat_ff == len_i;

    // Beat counter; a changing length can wrap it and stretch a burst past 4 beats
    always_ff @(posedge clk_i) begin
        if (rst_i || !(tx_gnt_i | rx_gnt_i)) begin
            beat_ff <= 2'h0;
        end else begin
            beat_ff <= beat_ff + 2'h1;
        end
    end
endmodule

// ---- bench/test_tra_arbiter.sv ----
// Random bench comparing the DMA arbiter with a reference model
`timescale 1ns/100ps
module test_tra_arbiter;
    import tra_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [1:0] bm = 2'h0;
    logic [1:0] thr = 2'h0;
    logic [1:0] len = 2'h0;
    logic [3:0] ctl = 4'h0; // Rx end, tx end, tx active, duplex
    logic [3:0] tc = 4'h0;
    logic [4:0] rc = 5'h0;
    logic [LVL_W-1:0] tl = '0;
    logic [LVL_W-1:0] rf = '0;
    logic tq, rq, tg, rg, sl, ll, done;
    logic [LVL_W-1:0] thtab [4] = '{9'h048, 9'h060, 9'h080, 9'h0a0};
    logic mtw = 1'b0;
    logic mrw = 1'b0;
    logic ml = 1'b0;
    int mg = 0;
    int mismatches = 0;
    int n_compared = 0;
    int cyc = 0;

    // Expected requests and low flags from the inputs
    wire logic eq = |tc;
    wire logic erq = |rc[2:0] | (rc[3] & rc[4]);
    wire logic esl = rf < thtab[thr];
    wire logic ell = tl < thtab[thr];

    tra_arbiter tra_arbiter_i (
        .clk_i(clk_i), .rst_i(rst_i), .bus_mode_register_i(bm),
        .thr_code_i(thr), .full_duplex_i(ctl[0]), .tx_active_i(ctl[1]),
        .tx_desc_fetch_i(tc[0]), .tx_desc_close_i(tc[1]),
        .tx_setup_i(tc[2]), .tx_room_burst_i(tc[3]), .tx_level_i(tl),
        .tx_pkt_end_i(ctl[2]), .rx_desc_fetch_i(rc[0]),
        .rx_desc_close_i(rc[1]), .rx_burst_ready_i(rc[2]),
        .rx_frame_end_i(rc[3]), .rx_data_left_i(rc[4]), .rx_free_i(rf),
        .rx_pkt_end_i(ctl[3]), .burst_done_i(done), .tx_req_o(tq),
        .rx_req_o(rq), .tx_gnt_o(tg), .rx_gnt_o(rg),
        .rx_space_low_o(sl), .tx_level_low_o(ll)
    );
    tra_dma_model tra_dma_model_i (
        .clk_i(clk_i), .rst_i(rst_i), .tx_gnt_i(tg), .rx_gnt_i(rg),
        .len_i(len), .burst_done_o(done)
    );

    // 10 MHz clock
    always #50 clk_i = ~clk_i;

    task automatic chk(input logic [3:0] e, input logic [3:0] g);
        n_compared++;
        if (e !== g) begin
            mismatches++;
            $display("CHECK FAILED at %0t exp %h got %h", $time, e, g);
        end
    endtask

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Reference arbiter: 0 idle, 1 transmit, 2 receive
    always @(posedge clk_i) begin
        int nx;
        int pref;
        pref = bm[1] ? 1 : 2;
        nx = 0;
        if (mg == 0 && eq && erq) begin
            if (mtw) nx = 1;
            else if (mrw) nx = 2;
            else if (!ctl[1]) nx = pref;
            else if (!esl) nx = 1;
            else if (!ell) nx = 2;
            else if (ctl[0]) nx = ml ? 1 : 2;
            else nx = pref;
        end else if (mg == 0) begin
            nx = eq ? 1 : (erq ? 2 : 0);
        end else if (!done) begin
            nx = mg;
        end
        mtw = ctl[3] | (mtw & !(mg == 1 && done));
        mrw = ctl[2] | (mrw & !(mg == 2 && done));
        if (mg == 0 && nx != 0) ml = nx == 2;
        mg = nx;
        if (rst_i) begin
            mg = 0;
            mtw = 1'b0;
            mrw = 1'b0;
            ml = 1'b0;
        end
    end

    // Results are settled mid-cycle
    always @(negedge clk_i) begin
        if (cyc > 0) begin
            chk(4'(mg), {2'h0, rg, tg});
            chk({2'h0, erq, eq}, {2'h0, rq, tq});
            chk({2'h0, ell, esl}, {2'h0, ll, sl});
        end
    end

    // Hang guard
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 4000) begin
            mismatches++;
            end_of_test();
        end
    end

    initial begin
        void'($urandom(83985));
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3000) begin
            @(posedge clk_i);
            // Rare resets and packet ends so windows do not always win
            rst_i <= $urandom % 500 == 0;
            bm <= 2'($urandom);
            thr <= 2'($urandom);
            len <= 2'($urandom);
            ctl <= {$urandom % 24 == 0, $urandom % 24 == 0, 2'($urandom)};
            tc <= 4'($urandom & $urandom);
            rc <= 5'($urandom & $urandom);
            tl <= 9'($urandom % 200);
            rf <= 9'($urandom % 200);
        end
        end_of_test();
    end
endmodule
